// ==== bench/degio_core_model.sv ====
// Core-side partner that makes the two core clocks and the core data bits.
`timescale 1ns/1ns
module degio_core_model (
   input  wire logic clk_i,          // System clock
   output logic      launch_clock_o, // Core launch clock
   output logic      capture_clock_o,// Core capture clock
   output logic      out_rise_o,     // Rising-edge data bit
   output logic      out_fall_o,     // Falling-edge data bit
   output logic      drive_enable_o  // Drive enable
);
   initial begin
      {launch_clock_o, capture_clock_o, out_rise_o, out_fall_o, drive_enable_o} = 5'h00;
   end
   // Both bits are supplied together; the pad logic picks the edge for each.
   task automatic set_out(input logic r, input logic f, input logic en);
      @(posedge clk_i);
      out_rise_o <= r;
      out_fall_o <= f;
      drive_enable_o <= en;
   endtask : set_out
   // Half periods stay far above the synchroniser delay of the pad logic.
   task automatic toggle_launch();
      @(posedge clk_i);
      launch_clock_o <= ~launch_clock_o;
      repeat (7) @(posedge clk_i);
      #1;
   endtask : toggle_launch
   task automatic toggle_capture();
      @(posedge clk_i);
      capture_clock_o <= ~capture_clock_o;
      repeat (7) @(posedge clk_i);
      #1;
   endtask : toggle_capture
endmodule : degio_core_model

// ==== bench/degio_properties.sv ====
// Checker that ties the pad logic outputs to their causes at the ports.
`timescale 1ns/1ns
module degio_properties #(
   parameter bit DIFF_PAIR = 1'b0                 // Pin on a differential-pair resource
) (
   input wire logic                         CLK_I,                  // Clock
   input wire logic                         RESETN_I,               // Reset, active low
   input wire logic                         CE_I,                   // Clock enable
   input wire logic [degio_pkg::ADDR_W-1:0] ADDR_I,                 // Address
   input wire logic                         WR_I,                   // Write strobe
   input wire logic                         RD_I,                   // Read strobe
   input wire logic [degio_pkg::DATA_W-1:0] RDATA_O,                // Read data
   input wire logic                         PAD_I,                  // Pad level
   input wire logic                         PAD_O,                  // Pad drive
   input wire logic                         PAD_OE_O,               // Pad enable
   input wire logic                         PULL_DOWN_O,            // Pull-down
   input wire logic                         CAPTURE_CLOCK_I,        // Capture clock
   input wire logic                         LAUNCH_CLOCK_I,         // Launch clock
   input wire logic                         CORE_OUT_RISE_I,        // Core rise bit
   input wire logic                         CORE_OUT_FALL_I,        // Core fall bit
   input wire logic                         DRIVE_ENABLE_I,         // Core enable
   input wire logic                         PAD_SAMPLE_RISE_O,      // Rise sample
   input wire logic                         PAD_SAMPLE_FALL_O,      // Fall sample
   input wire logic                         GLOBAL_CLOCK_NET_O,     // Bypass route 0
   input wire logic                         GLOBAL_CONTROL_NET_O,   // Bypass route 1
   input wire logic                         SYNTH_REF_CLOCK_O,      // Bypass route 2
   input wire logic                         CAMERA_LINK_REF_CLOCK_O // Bypass route 3
);
   import degio_pkg::*;
   logic [3:0] byp;
   assign byp = {CAMERA_LINK_REF_CLOCK_O, SYNTH_REF_CLOCK_O, GLOBAL_CONTROL_NET_O,
                 GLOBAL_CLOCK_NET_O};
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESETN_I);
   rdata_idle_a: assert property (CE_I && !RD_I |=> RDATA_O == '0)
      else $error("read data not zero outside the read answer cycle");
   unmapped_read_a: assert property (CE_I && RD_I && ADDR_I == 4'hc |=> RDATA_O == '0)
      else $error("unmapped read returned nonzero data");
   no_pulldown_a: assert property (DIFF_PAIR |-> !PULL_DOWN_O)
      else $error("pull-down enabled on a differential-pair pin");
   bypass_hot_a: assert property ($onehot0(byp))
      else $error("more than one bypass route active");
   bypass_low_a: assert property ((!PAD_I) [*4] |-> byp == 4'h0)
      else $error("bypass route high while pad is low");
   // Six quiet samples cover the three-edge synchroniser delay with margin.
   out_still_a: assert property (
      (CE_I && !WR_I && $stable(LAUNCH_CLOCK_I) && $stable(CORE_OUT_RISE_I)
       && $stable(CORE_OUT_FALL_I) && $stable(DRIVE_ENABLE_I)) [*6]
      |=> $stable(PAD_O) && $stable(PAD_OE_O))
      else $error("pad drive moved without a launch edge or core change");
   in_still_a: assert property (
      (CE_I && !WR_I && $stable(PAD_I) && $stable(CAPTURE_CLOCK_I)) [*6]
      |=> $stable(PAD_SAMPLE_RISE_O) && $stable(PAD_SAMPLE_FALL_O))
      else $error("pad samples moved without a capture edge or pad change");
   status_view_a: assert property (CE_I && RD_I && ADDR_I == STATUS_ADDR |=>
      RDATA_O[STS_OE] == $past(PAD_OE_O) && RDATA_O[STS_PAD_OUT] == $past(PAD_O)
      && RDATA_O[STS_DIFF] == DIFF_PAIR)
      else $error("status read disagrees with pad drive outputs");
   cover property (RD_I && ADDR_I == STATUS_ADDR);
   cover property ($rose(PAD_OE_O));
   cover property ($rose(SYNTH_REF_CLOCK_O));
endmodule : degio_properties
bind degio_top degio_properties #(.DIFF_PAIR(DIFF_PAIR)) degio_properties_i (.*);

// ==== bench/degio_top_tb.sv ====
// Self-checking bench for the pad logic with a core-side partner model.
`timescale 1ns/1ns
module degio_top_tb;
   import degio_pkg::*;
   logic              CLK_I = 1'b0, RESETN_I = 1'b0, CE_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;
   logic [ADDR_W-1:0] ADDR_I = '0;
   logic [DATA_W-1:0] WDATA_I = '0;
   logic [DATA_W-1:0] RDATA_O, rdata2;
   logic              PAD_O, PAD_OE_O, PULL_UP_O, PULL_DOWN_O, PAD_SAMPLE_RISE_O, PAD_SAMPLE_FALL_O;
   logic              GLOBAL_CLOCK_NET_O, GLOBAL_CONTROL_NET_O, SYNTH_REF_CLOCK_O;
   logic              CAMERA_LINK_REF_CLOCK_O, CAPTURE_CLOCK_I, LAUNCH_CLOCK_I;
   logic              CORE_OUT_RISE_I, CORE_OUT_FALL_I, DRIVE_ENABLE_I;
   logic              ext_en = 1'b1, pad_ext = 1'b0, pad_last = 1'b0;
   int                num_errors = 0, check_count = 0, cycles = 0;
   // An undriven pad with no pull shows a changing level, never a held one.
   wire               PAD_I = PAD_OE_O ? PAD_O : ext_en ? pad_ext :
                              PULL_UP_O ? 1'b1 : PULL_DOWN_O ? 1'b0 : ~pad_last;
   wire [3:0]         byp = {CAMERA_LINK_REF_CLOCK_O, SYNTH_REF_CLOCK_O,
                             GLOBAL_CONTROL_NET_O, GLOBAL_CLOCK_NET_O};
   degio_top degio_top_i (.*);
   degio_top #(.DIFF_PAIR(1'b1)) degio_top_diff_i (.*, .RDATA_O(rdata2), .PAD_O(), .PAD_OE_O(),
      .PULL_UP_O(), .PULL_DOWN_O(), .PAD_SAMPLE_RISE_O(), .PAD_SAMPLE_FALL_O(),
      .GLOBAL_CLOCK_NET_O(), .GLOBAL_CONTROL_NET_O(), .SYNTH_REF_CLOCK_O(),
      .CAMERA_LINK_REF_CLOCK_O());
   degio_core_model degio_core_model_i (.clk_i(CLK_I), .launch_clock_o(LAUNCH_CLOCK_I),
      .capture_clock_o(CAPTURE_CLOCK_I), .out_rise_o(CORE_OUT_RISE_I),
      .out_fall_o(CORE_OUT_FALL_I), .drive_enable_o(DRIVE_ENABLE_I));
   initial begin
      forever #25 CLK_I = ~CLK_I;
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   always @(posedge CLK_I) begin
      pad_last <= PAD_I;
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'b1;
      @(posedge CLK_I);
      WR_I <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] e2);
      @(posedge CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      #1;
      check(RDATA_O, e);
      check(rdata2, e2);
   endtask : rd_chk
   task automatic ext(input logic en, input logic v);
      @(posedge CLK_I);
      ext_en <= en;
      pad_ext <= v;
      repeat (5) @(posedge CLK_I);
      #1;
   endtask : ext
   task automatic t_regs();
      rd_chk(CONFIG_ADDR, 32'h0, 32'h0);
      rd_chk(ROUTE_ADDR, 32'h0, 32'h0);
      rd_chk(4'hc, 32'h0, 32'h0);
      rd_chk(STATUS_ADDR, 32'h0, 32'h10);
      wr(CONFIG_ADDR, 32'hffffffff);
      wr(4'hc, 32'h0);
      rd_chk(CONFIG_ADDR, 32'h7ff, 32'h3bf);
      check({PULL_UP_O, PULL_DOWN_O}, 2'h3);
      wr(CONFIG_ADDR, 32'h0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_plain();
      ext(1'b0, 1'b0);
      degio_core_model_i.set_out(1'b1, 1'b0, 1'b1);
      ext(1'b0, 1'b0);
      check({PAD_OE_O, PAD_O, PAD_SAMPLE_RISE_O}, 3'h7);
      degio_core_model_i.set_out(1'b0, 1'b0, 1'b0);
      ext(1'b1, 1'b1);
      check({PAD_OE_O, PAD_SAMPLE_RISE_O}, 2'h1);
      rd_chk(STATUS_ADDR, 32'h5, 32'h15);
      $display("test plain done");
   endtask : t_plain
   task automatic t_regout();
      ext(1'b0, 1'b0);
      wr(CONFIG_ADDR, 32'h106);
      degio_core_model_i.set_out(1'b1, 1'b0, 1'b1);
      degio_core_model_i.toggle_launch();
      check({PAD_OE_O, PAD_O}, 2'h2);
      degio_core_model_i.set_out(1'b0, 1'b0, 1'b0);
      ext(1'b0, 1'b0);
      check({PAD_OE_O, PAD_O}, 2'h2);
      degio_core_model_i.toggle_launch();
      check({PAD_OE_O, PAD_O}, 2'h2);
      degio_core_model_i.toggle_launch();
      check({PAD_OE_O, PAD_O}, 2'h1);
      wr(CONFIG_ADDR, 32'h116);
      degio_core_model_i.set_out(1'b1, 1'b0, 1'b1);
      degio_core_model_i.toggle_launch();
      check({PAD_OE_O, PAD_O}, 2'h0);
      $display("test registered out done");
   endtask : t_regout
   task automatic t_ddr_out();
      wr(CONFIG_ADDR, 32'h46);
      degio_core_model_i.toggle_launch();
      check(PAD_O, 1'b1);
      degio_core_model_i.toggle_launch();
      check(PAD_O, 1'b0);
      wr(CONFIG_ADDR, 32'hc6);
      degio_core_model_i.set_out(1'b0, 1'b1, 1'b1);
      degio_core_model_i.toggle_launch();
      check(PAD_O, 1'b0);
      degio_core_model_i.set_out(1'b1, 1'b0, 1'b1);
      degio_core_model_i.toggle_launch();
      check(PAD_O, 1'b1);
      $display("test dual out done");
   endtask : t_ddr_out
   task automatic cap(input logic v);
      ext(1'b1, v);
      degio_core_model_i.toggle_capture();
   endtask : cap
   task automatic t_ddr_in();
      wr(CONFIG_ADDR, 32'h41);
      degio_core_model_i.set_out(1'b0, 1'b0, 1'b0);
      cap(1'b0);
      cap(1'b1);
      check({PAD_SAMPLE_RISE_O, PAD_SAMPLE_FALL_O}, 2'h1);
      wr(CONFIG_ADDR, 32'hc1);
      cap(1'b1);
      cap(1'b0);
      cap(1'b1);
      cap(1'b1);
      check({PAD_SAMPLE_RISE_O, PAD_SAMPLE_FALL_O}, 2'h2);
      cap(1'b0);
      check({PAD_SAMPLE_RISE_O, PAD_SAMPLE_FALL_O}, 2'h1);
      $display("test dual in done");
   endtask : t_ddr_in
   task automatic t_bypass();
      wr(CONFIG_ADDR, 32'h0);
      ext(1'b1, 1'b1);
      for (int r = 0; r < 4; r++) begin
         wr(ROUTE_ADDR, r);
         ext(1'b1, 1'b1);
         check(byp, 4'h1 << r);
      end
      ext(1'b1, 1'b0);
      check(byp, 4'h0);
      // With the clock enable low the pad change must not reach the route.
      @(posedge CLK_I);
      CE_I <= 1'b0;
      ext(1'b1, 1'b1);
      check(byp, 4'h0);
      @(posedge CLK_I);
      CE_I <= 1'b1;
      ext(1'b1, 1'b1);
      check(byp, 4'h8);
      $display("test bypass done");
   endtask : t_bypass
   initial begin
      repeat (6) @(posedge CLK_I);
      RESETN_I <= 1'b1;
      repeat (4) @(posedge CLK_I);
      t_regs();
      t_plain();
      t_regout();
      t_ddr_out();
      t_ddr_in();
      t_bypass();
      finish_test();
   end
endmodule : degio_top_tb

// ==== hdl/degio_pkg.sv ====
// Package with the register map, field positions and reset values of the pad logic.
package degio_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // Register byte addresses.
   localparam logic [ADDR_W-1:0] CONFIG_ADDR = 4'h0;
   localparam logic [ADDR_W-1:0] ROUTE_ADDR  = 4'h4;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h8;

   // Configuration register field positions.
   localparam int CFG_IN_REG    = 0;
   localparam int CFG_OUT_REG   = 1;
   localparam int CFG_OE_REG    = 2;
   localparam int CFG_IN_FALL   = 3;
   localparam int CFG_OUT_FALL  = 4;
   localparam int CFG_OE_FALL   = 5;
   localparam int CFG_DUAL_EDGE = 6;
   localparam int CFG_RESYNC    = 7;
   localparam int CFG_OUT_INV   = 8;
   localparam int CFG_PULL_UP   = 9;
   localparam int CFG_PULL_DOWN = 10;
   localparam int CFG_W         = 11;
   localparam logic [CFG_W-1:0] CONFIG_RESET = 11'h000;

   // Bypass route field, one code per destination.
   localparam int ROUTE_W = 2;
   localparam logic [ROUTE_W-1:0] ROUTE_RESET = 2'h0;
   localparam logic [ROUTE_W-1:0] ROUTE_GLOBAL_CLOCK_NET  = 2'h0;
   localparam logic [ROUTE_W-1:0] ROUTE_GLOBAL_CONTROL_NET = 2'h1;
   localparam logic [ROUTE_W-1:0] ROUTE_SYNTH = 2'h2;
   localparam logic [ROUTE_W-1:0] ROUTE_CAM   = 2'h3;

   // Status register field positions.
   localparam int STS_PAD     = 0;
   localparam int STS_OE      = 1;
   localparam int STS_RISE    = 2;
   localparam int STS_FALL    = 3;
   localparam int STS_DIFF    = 4;
   localparam int STS_PAD_OUT = 5;

   // Index of each asynchronous input in the synchroniser bank.
   localparam int SYN_PAD = 0;
   localparam int SYN_CAP = 1;
   localparam int SYN_LAU = 2;
   localparam int SYN_N   = 3;

endpackage : degio_pkg

// ==== hdl/degio_top.sv ====
// Pad I/O logic with optional registers, dual-edge capture and launch, and a bypass input.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////////////////////////
module degio_top #(
   parameter bit DIFF_PAIR = 1'b0                     // Pin sits on a differential-pair resource
) (
   input  wire logic                         CLK_I,              // System clock, 20 MHz
   input  wire logic                         RESETN_I,           // Asynchronous reset, active low
   input  wire logic                         CE_I,               // Clock enable, freezes state
   input  wire logic [degio_pkg::ADDR_W-1:0] ADDR_I,             // Register byte address
   input  wire logic [degio_pkg::DATA_W-1:0] WDATA_I,            // Register write data
   input  wire logic                         WR_I,               // Write strobe
   input  wire logic                         RD_I,               // Read strobe
   output logic      [degio_pkg::DATA_W-1:0] RDATA_O,            // Read data, cycle after strobe
   input  wire logic                         PAD_I,              // Pad level seen at the buffer
   output logic                              PAD_O,              // Pad drive value
   output logic                              PAD_OE_O,           // Pad driver enable, high drives
   output logic                              PULL_UP_O,          // Weak pull-up enable
   output logic                              PULL_DOWN_O,        // Weak pull-down enable
   input  wire logic                         CAPTURE_CLOCK_I,    // Core clock for input registers
   input  wire logic                         LAUNCH_CLOCK_I,     // Core clock for output registers
   input  wire logic                         CORE_OUT_RISE_I,    // Core data, rising-edge bit
   input  wire logic                         CORE_OUT_FALL_I,    // Core data, falling-edge bit
   input  wire logic                         DRIVE_ENABLE_I,     // Core drive enable
   output logic                              PAD_SAMPLE_RISE_O,  // Pad sample, rising-edge bit
   output logic                              PAD_SAMPLE_FALL_O,  // Pad sample, falling-edge bit
   output logic                              GLOBAL_CLOCK_NET_O, // Bypass to global clock net
   output logic                              GLOBAL_CONTROL_NET_O, // Bypass to control net
   output logic                              SYNTH_REF_CLOCK_O,  // Bypass to synthesizer ref
   output logic                              CAMERA_LINK_REF_CLOCK_O // Bypass to camera link ref
);
   import degio_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Synchronisers for the pad and the two core clocks, which arrive from other domains.

   logic [SYN_N-1:0] async_in;
   logic [SYN_N-1:0] sync_a;
   logic [SYN_N-1:0] sync_b;
   logic [SYN_N-1:0] sync_c;

   assign async_in = {LAUNCH_CLOCK_I, CAPTURE_CLOCK_I, PAD_I};

   genvar g;
   generate
      for (g = 0; g < SYN_N; g++) begin : g_sync
         always_ff @(posedge CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
               sync_a[g] <= 1'b0;
               sync_b[g] <= 1'b0;
               sync_c[g] <= 1'b0;
            end else if (CE_I) begin
               sync_a[g] <= async_in[g];
               sync_b[g] <= sync_a[g];
               sync_c[g] <= sync_b[g];
            end
         end
      end
   endgenerate

   logic pad_level;
   logic cap_rise;
   logic cap_fall;
   logic lau_rise;
   logic lau_fall;

   // Edges of the core clocks are seen as transitions of their synchronised copies.
   assign pad_level = sync_b[SYN_PAD];
   assign cap_rise  = sync_b[SYN_CAP] & ~sync_c[SYN_CAP];
   assign cap_fall  = ~sync_b[SYN_CAP] & sync_c[SYN_CAP];
   assign lau_rise  = sync_b[SYN_LAU] & ~sync_c[SYN_LAU];
   assign lau_fall  = ~sync_b[SYN_LAU] & sync_c[SYN_LAU];

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [CFG_W-1:0]   config_q;
   logic [ROUTE_W-1:0] route;
   logic [DATA_W-1:0]  rdata;
   logic [CFG_W-1:0]   next_config;
   logic [ROUTE_W-1:0] next_route;
   logic [DATA_W-1:0]  next_rdata;
   logic               dual_ok;

   // A differential-pair pin never enters dual-edge mode, whatever software writes.
   assign dual_ok = config_q[CFG_DUAL_EDGE] & ~DIFF_PAIR;

   always_comb begin
      next_config = config_q;
      next_route  = route;
      next_rdata  = '0;
      if (WR_I && ADDR_I == CONFIG_ADDR) begin
         next_config = WDATA_I[CFG_W-1:0];
         if (DIFF_PAIR) begin
            next_config[CFG_PULL_DOWN] = 1'b0;
            next_config[CFG_DUAL_EDGE] = 1'b0;
         end
      end
      if (WR_I && ADDR_I == ROUTE_ADDR) begin
         next_route = WDATA_I[ROUTE_W-1:0];
      end
      if (RD_I) begin
         case (ADDR_I)
            CONFIG_ADDR: next_rdata[CFG_W-1:0] = config_q;
            ROUTE_ADDR:  next_rdata[ROUTE_W-1:0] = route;
            STATUS_ADDR: begin
               next_rdata[STS_PAD]     = pad_level;
               next_rdata[STS_OE]      = PAD_OE_O;
               next_rdata[STS_RISE]    = PAD_SAMPLE_RISE_O;
               next_rdata[STS_FALL]    = PAD_SAMPLE_FALL_O;
               next_rdata[STS_DIFF]    = DIFF_PAIR;
               next_rdata[STS_PAD_OUT] = PAD_O;
            end
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         config_q <= CONFIG_RESET;
         route    <= ROUTE_RESET;
         RDATA_O  <= '0;
      end else if (CE_I) begin
         config_q <= next_config;
         route    <= next_route;
         RDATA_O  <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Output and drive-enable paths; the optional registers step on launch clock edges, unregistered paths follow the core each clock.

   logic out_hold_fall;
   logic oe_q;
   logic next_pad;
   logic next_oe;
   logic next_out_hold_fall;
   logic next_oe_q;
   logic out_edge;
   logic oe_edge;
   logic out_val;

   assign out_edge = config_q[CFG_OUT_FALL] ? lau_fall : lau_rise;
   assign oe_edge  = config_q[CFG_OE_FALL] ? lau_fall : lau_rise;

   always_comb begin
      next_pad           = PAD_O;
      next_out_hold_fall = out_hold_fall;
      next_oe_q          = oe_q;
      out_val            = PAD_O ^ config_q[CFG_OUT_INV];
      if (oe_edge) begin
         next_oe_q = DRIVE_ENABLE_I;
      end
      if (!config_q[CFG_OUT_REG]) begin
         out_val = CORE_OUT_RISE_I;
      end else if (dual_ok && config_q[CFG_RESYNC]) begin
         // Both bits are taken on the rising edge, the falling bit is replayed later.
         if (lau_rise) begin
            out_val            = CORE_OUT_RISE_I;
            next_out_hold_fall = CORE_OUT_FALL_I;
         end else if (lau_fall) begin
            out_val = out_hold_fall;
         end
      end else if (dual_ok) begin
         if (lau_rise) begin
            out_val = CORE_OUT_RISE_I;
         end else if (lau_fall) begin
            out_val = CORE_OUT_FALL_I;
         end
      end else if (out_edge) begin
         out_val = CORE_OUT_RISE_I;
      end
      // Inversion belongs to the output register only.
      next_pad = config_q[CFG_OUT_REG] ? out_val ^ config_q[CFG_OUT_INV] : out_val;
      next_oe  = config_q[CFG_OE_REG] ? next_oe_q : DRIVE_ENABLE_I;
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         PAD_O         <= 1'b0;
         PAD_OE_O      <= 1'b0;
         out_hold_fall <= 1'b0;
         oe_q          <= 1'b0;
      end else if (CE_I) begin
         PAD_O         <= next_pad;
         PAD_OE_O      <= next_oe;
         out_hold_fall <= next_out_hold_fall;
         oe_q          <= next_oe_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Input path; the pad is sampled whether or not the driver is enabled.

   logic in_hold_fall;
   logic next_rise;
   logic next_fall;
   logic next_in_hold_fall;
   logic in_edge;

   assign in_edge = config_q[CFG_IN_FALL] ? cap_fall : cap_rise;

   always_comb begin
      next_rise         = PAD_SAMPLE_RISE_O;
      next_fall         = PAD_SAMPLE_FALL_O;
      next_in_hold_fall = in_hold_fall;
      if (!config_q[CFG_IN_REG]) begin
         next_rise = pad_level;
      end else if (dual_ok && config_q[CFG_RESYNC]) begin
         // The falling capture waits half a cycle to appear beside the rising one.
         if (cap_fall) begin
            next_in_hold_fall = pad_level;
         end
         if (cap_rise) begin
            next_rise = pad_level;
            next_fall = in_hold_fall;
         end
      end else if (dual_ok) begin
         if (cap_rise) begin
            next_rise = pad_level;
         end
         if (cap_fall) begin
            next_fall = pad_level;
         end
      end else if (in_edge) begin
         next_rise = pad_level;
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         PAD_SAMPLE_RISE_O       <= 1'b0;
         PAD_SAMPLE_FALL_O       <= 1'b0;
         in_hold_fall            <= 1'b0;
      end else if (CE_I) begin
         PAD_SAMPLE_RISE_O       <= next_rise;
         PAD_SAMPLE_FALL_O       <= next_fall;
         in_hold_fall            <= next_in_hold_fall;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Bypass routes and pull controls.

   logic next_global_clock_net;
   logic next_global_control_net;
   logic next_synth;
   logic next_cam;
   logic next_pull_up;
   logic next_pull_down;

   // The bypass takes no capture register, only the synchroniser and the output stage.
   // Registering it adds latency but keeps every output on a flip-flop; a clock routed
   // this way therefore has to be far slower than the system clock.
   always_comb begin
      next_global_clock_net      = (route == ROUTE_GLOBAL_CLOCK_NET) & pad_level;
      next_global_control_net     = (route == ROUTE_GLOBAL_CONTROL_NET) & pad_level;
      next_synth     = (route == ROUTE_SYNTH) & pad_level;
      next_cam       = (route == ROUTE_CAM) & pad_level;
      // A differential-pair pin keeps its pull-down off whatever the configuration says.
      next_pull_up   = config_q[CFG_PULL_UP];
      next_pull_down = config_q[CFG_PULL_DOWN] & ~DIFF_PAIR;
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         GLOBAL_CLOCK_NET_O      <= 1'b0;
         GLOBAL_CONTROL_NET_O    <= 1'b0;
         SYNTH_REF_CLOCK_O       <= 1'b0;
         CAMERA_LINK_REF_CLOCK_O <= 1'b0;
         PULL_UP_O               <= 1'b0;
         PULL_DOWN_O             <= 1'b0;
      end else if (CE_I) begin
         GLOBAL_CLOCK_NET_O      <= next_global_clock_net;
         GLOBAL_CONTROL_NET_O    <= next_global_control_net;
         SYNTH_REF_CLOCK_O       <= next_synth;
         CAMERA_LINK_REF_CLOCK_O <= next_cam;
         PULL_UP_O               <= next_pull_up;
         PULL_DOWN_O             <= next_pull_down;
      end
   end

endmodule : degio_top
